// file: logic/rpt_timer.sv
// Operation
// - Eight-bit main down-counter clocked by underflows of an eight-bit prescaler.
// - Prescaler and main counter each have reload and live counter at one address.
// - Prescaler counts one of five internal sources: div1, div2, div8, oscillator, sub/32.
// - Counters decrement and reload from their reload register on underflow, never stopping.
// - Main underflow rate is source divided by (n+1)(m+1).
// - Writing 1 to start request starts counting.
// - Writing 0 to start request stops counting and keeps counter contents.
// - Writing 1 to force stop halts counting at once, whatever start request says.
// - Force stop resets start request, status flag, prescaler and main counter.
// - Timer interrupt request raised on every main counter underflow.
// - Reads of prescaler or main counter return the live counter value.
// - Writes while stopped load reload register and counter together.
// - Prescaler write while counting reaches counter at next count source event.
// - Main write while counting reaches counter at next prescaler underflow.
// - Main counter decrements once per prescaler underflow, never otherwise.
// - Timer is stopped after reset.
// - Edge and underflow flags clear on written 0, unchanged on written 1.
// - Prescaler and main counter are separate byte-wide accesses, may change between them.
// - Status flag stays 0 up to one source cycle after start request.
// - Once status flag is 1, counting begins at next source edge.
// - Status flag stays 1 up to one source cycle after stop; counting stops at once with the request.
//
// Local design decisions: the placing of the registers and register access over AHB-Lite.
module rpt_timer
  import rpt_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic onchip_osc_clock,
  input wire logic subclock_div32,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output logic timer_irq
);

  localparam rpt_state_t ST_RST = '{
    req: 1'b0,
    stat: 1'b0,
    first: 1'b0,
    edge_f: 1'b0,
    undf: 1'b0,
    ioc: REG_RST,
    src: SRC_DIV1,
    pre_rel: CNT_RST,
    pre_cnt: CNT_RST,
    pre_pend: 1'b0,
    main_rel: CNT_RST,
    main_cnt: CNT_RST,
    main_pend: 1'b0,
    div: 3'h0,
    irq: 1'b0,
    wr_pend: 1'b0,
    wr_addr: 5'h00,
    rdata: 32'h0000_0000,
    ready: 1'b1,
    resp: 1'b0
  };

  rpt_state_t st_r;
  rpt_state_t st_nxt;

  logic tick;
  logic run;
  logic pre_uf;
  logic main_uf;
  logic addr_ok;
  logic wr_ctrl;
  logic wr_pre;
  logic wr_main;
  logic fstop;

  // Count source select; sysclk divisions come from a free-running divider
  always_comb begin
    unique case (st_r.src)
      SRC_DIV1: tick = 1'b1;
      SRC_DIV2: tick = st_r.div[0];
      SRC_DIV8: tick = (st_r.div == DIV_LAST);
      SRC_OSC: tick = onchip_osc_clock;
      SRC_SUB32: tick = subclock_div32;
      default: tick = 1'b0;
    endcase
  end

  // Counting only while both the request and the synchronised flag stand
  assign run = tick && st_r.stat && st_r.req;
  assign pre_uf = run && !st_r.pre_pend && (st_r.pre_cnt == '0);
  assign main_uf = pre_uf && !st_r.main_pend && (st_r.main_cnt == '0);

  assign addr_ok = hsel && htrans[1] && hready;
  assign wr_ctrl = st_r.wr_pend && (st_r.wr_addr == OFS_CTRL);
  assign wr_pre = st_r.wr_pend && (st_r.wr_addr == OFS_PRE);
  assign wr_main = st_r.wr_pend && (st_r.wr_addr == OFS_MAIN);
  assign fstop = wr_ctrl && hwdata[CTL_FSTOP];

  always_comb begin
    st_nxt = st_r;
    st_nxt.div = st_r.div + 3'h1;
    st_nxt.irq = main_uf;
    st_nxt.ready = 1'b1;
    st_nxt.resp = 1'b0;

    // Start/stop flag follows the request on a source edge
    if (tick) begin
      st_nxt.stat = st_r.req;
      if (st_r.req && !st_r.stat) begin
        st_nxt.first = 1'b1;
      end
    end

    // Prescaler
    if (run) begin
      if (st_r.pre_pend) begin
        st_nxt.pre_cnt = st_r.pre_rel;
        st_nxt.pre_pend = 1'b0;
      end else if (st_r.pre_cnt == '0) begin
        st_nxt.pre_cnt = st_r.pre_rel;
      end else begin
        st_nxt.pre_cnt = st_r.pre_cnt - 8'h01;
      end
    end

    // Main counter counts only on prescaler underflow
    if (pre_uf) begin
      st_nxt.first = 1'b0;
      if (st_r.main_pend) begin
        st_nxt.main_cnt = st_r.main_rel;
        st_nxt.main_pend = 1'b0;
      end else if (st_r.main_cnt == '0) begin
        st_nxt.main_cnt = st_r.main_rel;
      end else begin
        st_nxt.main_cnt = st_r.main_cnt - 8'h01;
      end
    end

    // Hardware-set flags; a set in the clearing cycle survives
    st_nxt.undf = st_r.undf | main_uf;
    st_nxt.edge_f = st_r.edge_f | (pre_uf && st_r.first);

    // Data phase of a write
    if (wr_ctrl) begin
      st_nxt.req = hwdata[CTL_START];
      st_nxt.undf = (st_r.undf && hwdata[CTL_UNDF]) || main_uf;
      st_nxt.edge_f = (st_r.edge_f && hwdata[CTL_EDGE]) || (pre_uf && st_r.first);
    end
    if (st_r.wr_pend && (st_r.wr_addr == OFS_IOC)) begin
      st_nxt.ioc = hwdata[7:0];
    end
    if (st_r.wr_pend && (st_r.wr_addr == OFS_MODE)) begin
      st_nxt.src = hwdata[MODE_SRC_LSB +: SRC_W];
    end
    if (wr_pre) begin
      st_nxt.pre_rel = hwdata[TMR_W-1:0];
      if (st_r.stat) begin
        st_nxt.pre_pend = 1'b1;
      end else begin
        st_nxt.pre_cnt = hwdata[TMR_W-1:0];
      end
    end
    if (wr_main) begin
      st_nxt.main_rel = hwdata[TMR_W-1:0];
      if (st_r.stat) begin
        st_nxt.main_pend = 1'b1;
      end else begin
        st_nxt.main_cnt = hwdata[TMR_W-1:0];
      end
    end

    // Forced stop overrides request, status and counter updates, but not flag sets or the interrupt
    if (fstop) begin
      st_nxt.req = 1'b0;
      st_nxt.stat = 1'b0;
      st_nxt.first = 1'b0;
      st_nxt.pre_rel = CNT_RST;
      st_nxt.pre_cnt = CNT_RST;
      st_nxt.pre_pend = 1'b0;
      st_nxt.main_rel = CNT_RST;
      st_nxt.main_cnt = CNT_RST;
      st_nxt.main_pend = 1'b0;
    end

    // Address phase: latch writes, sample read data for the data phase
    st_nxt.wr_pend = addr_ok && hwrite;
    st_nxt.wr_addr = haddr[4:0];
    st_nxt.rdata = 32'h0000_0000;
    if (addr_ok && !hwrite) begin
      unique case (haddr[4:0])
        OFS_CTRL: begin
          st_nxt.rdata[CTL_START] = st_r.req;
          st_nxt.rdata[CTL_STAT] = st_r.stat;
          st_nxt.rdata[CTL_EDGE] = st_r.edge_f;
          st_nxt.rdata[CTL_UNDF] = st_r.undf;
        end
        OFS_IOC: st_nxt.rdata[7:0] = st_r.ioc;
        OFS_MODE: st_nxt.rdata[MODE_SRC_LSB +: SRC_W] = st_r.src;
        OFS_PRE: st_nxt.rdata[TMR_W-1:0] = st_r.pre_cnt;
        OFS_MAIN: st_nxt.rdata[TMR_W-1:0] = st_r.main_cnt;
        default: st_nxt.rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_r <= ST_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign hrdata = st_r.rdata;
  assign hreadyout = st_r.ready;
  assign hresp = st_r.resp;
  assign timer_irq = st_r.irq;

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  property p_irq_uf;
    main_uf |=> timer_irq && (st_r.main_cnt == $past(st_r.main_rel));
  endproperty
  a_irq_uf: assert property (p_irq_uf) else $error("no irq or reload on main underflow");

  property p_main_hold;
    !pre_uf && !wr_main && !fstop |=> $stable(st_r.main_cnt);
  endproperty
  a_main_hold: assert property (p_main_hold) else $error("main counter moved without cause");

  property p_start_sync;
    tick && st_r.req && !st_r.stat && !st_r.wr_pend |=> st_r.stat;
  endproperty
  a_start_sync: assert property (p_start_sync) else $error("status flag did not follow start");

  property p_stop_sync;
    tick && !st_r.req && st_r.stat |=> !st_r.stat ##0 $stable(st_r.pre_cnt);
  endproperty
  a_stop_sync: assert property (p_stop_sync) else $error("counting after stop");

  property p_fstop;
    fstop |=> !st_r.req && !st_r.stat && st_r.pre_cnt == CNT_RST && st_r.main_cnt == CNT_RST;
  endproperty
  a_fstop: assert property (p_fstop) else $error("forced stop did not reset");

  property p_wr_stopped;
    wr_pre && !st_r.stat && !fstop |=> st_r.pre_cnt == $past(hwdata[7:0]) && st_r.pre_rel == st_r.pre_cnt;
  endproperty
  a_wr_stopped: assert property (p_wr_stopped) else $error("stopped write not loaded");

  property p_wr_running;
    wr_pre && st_r.stat && !fstop |=> st_r.pre_pend && st_r.pre_rel == $past(hwdata[7:0]);
  endproperty
  a_wr_running: assert property (p_wr_running) else $error("running write mishandled");

  property p_undf_keep;
    wr_ctrl && hwdata[CTL_UNDF] && !main_uf |=> st_r.undf == $past(st_r.undf);
  endproperty
  a_undf_keep: assert property (p_undf_keep) else $error("underflow flag changed on write of one");

  property p_rd_live;
    addr_ok && !hwrite && haddr[4:0] == OFS_PRE |=> hrdata[7:0] == $past(st_r.pre_cnt);
  endproperty
  a_rd_live: assert property (p_rd_live) else $error("prescaler read not live");

  property p_pre_dec;
    run && !st_r.pre_pend && st_r.pre_cnt != '0 && !fstop |=> st_r.pre_cnt == $past(st_r.pre_cnt) - 8'h01;
  endproperty
  a_pre_dec: assert property (p_pre_dec) else $error("prescaler did not decrement");

  property p_pre_reload;
    pre_uf && !fstop |=> st_r.pre_cnt == $past(st_r.pre_rel);
  endproperty
  a_pre_reload: assert property (p_pre_reload) else $error("prescaler did not reload on underflow");

  property p_main_dec;
    pre_uf && !st_r.main_pend && st_r.main_cnt != '0 && !fstop |=> st_r.main_cnt == $past(st_r.main_cnt) - 8'h01;
  endproperty
  a_main_dec: assert property (p_main_dec) else $error("main counter did not decrement");

  property p_main_pend;
    pre_uf && st_r.main_pend && !fstop |=> st_r.main_cnt == $past(st_r.main_rel);
  endproperty
  a_main_pend: assert property (p_main_pend) else $error("pending main value not loaded");

  property p_pre_pend;
    run && st_r.pre_pend && !fstop |=> st_r.pre_cnt == $past(st_r.pre_rel);
  endproperty
  a_pre_pend: assert property (p_pre_pend) else $error("pending prescaler value not loaded");

  property p_wr_main_stopped;
    wr_main && !st_r.stat |=> st_r.main_cnt == $past(hwdata[7:0]) && st_r.main_rel == st_r.main_cnt;
  endproperty
  a_wr_main_stopped: assert property (p_wr_main_stopped) else $error("stopped main write not loaded");

  property p_wr_main_running;
    wr_main && st_r.stat |=> st_r.main_pend && st_r.main_rel == $past(hwdata[7:0]);
  endproperty
  a_wr_main_running: assert property (p_wr_main_running) else $error("running main write mishandled");

  property p_no_count_stopped;
    !st_r.stat && !wr_pre && !fstop |=> $stable(st_r.pre_cnt);
  endproperty
  a_no_count_stopped: assert property (p_no_count_stopped) else $error("prescaler moved while stopped");

  property p_start_req;
    wr_ctrl && hwdata[CTL_START] && !hwdata[CTL_FSTOP] |=> st_r.req;
  endproperty
  a_start_req: assert property (p_start_req) else $error("start request not taken");

  property p_fstop_hold;
    fstop ##1 !wr_pre |=> st_r.pre_cnt == CNT_RST;
  endproperty
  a_fstop_hold: assert property (p_fstop_hold) else $error("counting after forced stop");

  property p_irq_only;
    !main_uf |=> !timer_irq;
  endproperty
  a_irq_only: assert property (p_irq_only) else $error("interrupt without underflow");

  property p_stat_hold0;
    !st_r.stat && !tick |=> !st_r.stat;
  endproperty
  a_stat_hold0: assert property (p_stat_hold0) else $error("status flag rose without source edge");

  property p_stat_hold1;
    st_r.stat && !tick && !fstop |=> st_r.stat;
  endproperty
  a_stat_hold1: assert property (p_stat_hold1) else $error("status flag fell without source edge");

  property p_edge_keep;
    wr_ctrl && hwdata[CTL_EDGE] && !(pre_uf && st_r.first) |=> st_r.edge_f == $past(st_r.edge_f);
  endproperty
  a_edge_keep: assert property (p_edge_keep) else $error("edge flag changed on write of one");

  property p_rd_main;
    addr_ok && !hwrite && haddr[4:0] == OFS_MAIN |=> hrdata[7:0] == $past(st_r.main_cnt);
  endproperty
  a_rd_main: assert property (p_rd_main) else $error("main counter read not live");

  property p_div_run;
    hresetn |=> st_r.div == $past(st_r.div) + 3'h1;
  endproperty
  a_div_run: assert property (p_div_run) else $error("source divider stalled");

endmodule

// file: logic/rpt_pkg.sv
package rpt_pkg;
  localparam int TMR_W = 8;

  // Byte offsets of the register words
  localparam logic [4:0] OFS_CTRL = 5'h00;
  localparam logic [4:0] OFS_IOC = 5'h04;
  localparam logic [4:0] OFS_MODE = 5'h08;
  localparam logic [4:0] OFS_PRE = 5'h0c;
  localparam logic [4:0] OFS_MAIN = 5'h10;

  // Control register bit positions
  localparam int CTL_START = 0;
  localparam int CTL_STAT = 1;
  localparam int CTL_FSTOP = 2;
  localparam int CTL_EDGE = 4;
  localparam int CTL_UNDF = 5;

  // Mode register source select field
  localparam int MODE_SRC_LSB = 4;
  localparam int SRC_W = 3;

  // Count source codes
  localparam logic [2:0] SRC_DIV1 = 3'h0;
  localparam logic [2:0] SRC_DIV8 = 3'h1;
  localparam logic [2:0] SRC_OSC = 3'h2;
  localparam logic [2:0] SRC_DIV2 = 3'h3;
  localparam logic [2:0] SRC_SUB32 = 3'h4;

  // Reset values and the last source divider count
  localparam logic [7:0] CNT_RST = 8'hff;
  localparam logic [7:0] REG_RST = 8'h00;
  localparam logic [2:0] DIV_LAST = 3'h7;

  typedef struct packed {
    logic req;
    logic stat;
    logic first;
    logic edge_f;
    logic undf;
    logic [7:0] ioc;
    logic [SRC_W-1:0] src;
    logic [TMR_W-1:0] pre_rel;
    logic [TMR_W-1:0] pre_cnt;
    logic pre_pend;
    logic [TMR_W-1:0] main_rel;
    logic [TMR_W-1:0] main_cnt;
    logic main_pend;
    logic [2:0] div;
    logic irq;
    logic wr_pend;
    logic [4:0] wr_addr;
    logic [31:0] rdata;
    logic ready;
    logic resp;
  } rpt_state_t;
endpackage

// file: test/tb_reload_prescaled_timer.sv
module tb_reload_prescaled_timer
  import rpt_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] RUN = (32'h1 << CTL_START) | (32'h1 << CTL_STAT);
  localparam logic [31:0] FLAGS = (32'h1 << CTL_EDGE) | (32'h1 << CTL_UNDF);
  logic hclk;
  logic hresetn;
  logic hsel;
  logic hwrite;
  logic hready;
  logic osc_en = 1'b0;
  logic sub_en = 1'b0;
  logic [31:0] haddr;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic [31:0] q;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic hreadyout;
  logic hresp;
  logic timer_irq;
  int n_mismatch = 0;
  int checked = 0;
  int cyc = 0;
  int t;
  // Ordinary cases: write then read back while stopped
  logic [4:0] row_a [4] = '{OFS_IOC, OFS_PRE, OFS_MAIN, 5'h14};
  logic [31:0] row_d [4] = '{32'h5a, 32'h07, 32'h03, 32'h77};
  logic [31:0] row_q [4] = '{32'h5a, 32'h07, 32'h03, 32'h00};
  // Count sources and their hclk cycles per tick
  logic [2:0] src_c [5] = '{SRC_DIV1, SRC_DIV2, SRC_DIV8, SRC_OSC, SRC_SUB32};
  int src_m [5] = '{1, 2, 8, 3, 5};

  assign hready = hreadyout;

  rpt_timer uut (
    .hclk(hclk),
    .hresetn(hresetn),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hsize(hsize),
    .hwdata(hwdata),
    .hready(hready),
    .onchip_osc_clock(osc_en),
    .subclock_div32(sub_en),
    .hrdata(hrdata),
    .hreadyout(hreadyout),
    .hresp(hresp),
    .timer_irq(timer_irq)
  );

  initial begin
    hclk = 1'b0;
    forever #20 hclk = ~hclk;
  end

  always @(posedge hclk) begin
    cyc <= cyc + 1;
    osc_en <= (cyc % 3 == 0);
    sub_en <= (cyc % 5 == 0);
    if (cyc == 20000) begin
      n_mismatch++;
      end_of_test();
    end
  end

  task automatic end_of_test();
    if (n_mismatch == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic xfer(input logic [4:0] a, input logic w, input logic [31:0] d, output logic [31:0] r);
    haddr <= {27'h0, a};
    hwrite <= w;
    htrans <= 2'h2;
    hsel <= 1'b1;
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    r = hrdata;
    chk({31'h0, hresp}, 32'h0);
  endtask

  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    logic [31:0] r;
    xfer(a, 1'b1, d, r);
  endtask

  task automatic rd_chk(input logic [4:0] a, input logic [31:0] exp);
    logic [31:0] r;
    xfer(a, 1'b0, 32'h0, r);
    chk(r, exp);
  endtask

  // Cycles from the call to the next interrupt pulse, at most 3000
  task automatic wait_irq(output int n);
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (timer_irq !== 1'b1 && n < 3000);
    if (timer_irq !== 1'b1) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: no timer interrupt", $time);
      end_of_test();
    end
  endtask

  task automatic period(input int exp);
    wait_irq(t);
    wait_irq(t);
    chk(32'(t), 32'(exp));
  endtask

  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd_chk(OFS_CTRL, 32'h0);
    rd_chk(OFS_PRE, {24'h0, CNT_RST});
    for (int i = 0; i < 4; i++) begin
      wr(row_a[i], row_d[i]);
      rd_chk(row_a[i], row_q[i]);
    end
    for (int i = 0; i < 5; i++) begin
      wr(OFS_CTRL, 32'h1 << CTL_FSTOP);
      rd_chk(OFS_MAIN, {24'h0, CNT_RST});
      rd_chk(OFS_CTRL, 32'h0);
      wr(OFS_MODE, {29'h0, src_c[i]} << MODE_SRC_LSB);
      wr(OFS_PRE, 32'h01);
      wr(OFS_MAIN, 32'h02);
      wr(OFS_CTRL, 32'h1 << CTL_START);
      period(6 * src_m[i]);
    end
    rd_chk(OFS_CTRL, RUN | FLAGS);
    wr(OFS_CTRL, 32'h1 << CTL_FSTOP);
    wr(OFS_MODE, {29'h0, SRC_DIV1} << MODE_SRC_LSB);
    wr(OFS_PRE, 32'h01);
    wr(OFS_MAIN, 32'h02);
    wr(OFS_CTRL, 32'h1 << CTL_START);
    wait_irq(t);
    wr(OFS_MAIN, 32'h04);
    period(10);
    wr(OFS_PRE, 32'h03);
    period(20);
    wr(OFS_CTRL, FLAGS);
    repeat (3) @(posedge hclk);
    rd_chk(OFS_CTRL, FLAGS);
    xfer(OFS_MAIN, 1'b0, 32'h0, q);
    repeat (10) @(posedge hclk);
    rd_chk(OFS_MAIN, q);
    wr(OFS_CTRL, 32'h0);
    rd_chk(OFS_CTRL, 32'h0);
    end_of_test();
  end
endmodule
